//--- bench/acp_host_model.sv
// Host side of the configuration port: serial enable, shift clock and data.
// Assumes the bench calls its tasks; all pins change at core clock falls.
`timescale 1ns/1ps
module acp_host_model
	import acp_pkg::*;
(
	input wire logic clock, // Core clock, paces the pins
	output logic [1:0] select_strobe_n, // Enable pin level code
	output logic shift_clock_pin, // Shift clock, idles high
	output logic shift_data_pin // Shift data
);
	// Idle: enable off, clock stands still between frames
	initial begin
		select_strobe_n = LVL_FULL;
		shift_clock_pin = 1'b1;
		shift_data_pin = 1'b0;
	end
	// Wait whole core cycles
	task automatic wt(input int n);
		repeat (n) @(negedge clock);
	endtask
	// Static straps for pin-only mode
	task automatic set_static(input logic [1:0] en, input logic sc, input logic sd);
		@(negedge clock);
		select_strobe_n = en;
		shift_clock_pin = sc;
		shift_data_pin = sd;
	endtask
	// Enable drops well before the first fall
	task automatic open_frame(input logic [1:0] en);
		@(negedge clock);
		shift_clock_pin = 1'b1;
		select_strobe_n = en;
		wt(4);
	endtask
	// Top n bits, MSB first; 80 ns shift clock period
	task automatic put(input logic [15:0] w, input int n);
		for (int i = 15; i > 15 - n; i--) begin
			shift_data_pin = w[i];
			wt(4);
			shift_clock_pin = 1'b0;
			wt(4);
			shift_clock_pin = 1'b1;
		end
	endtask
	// Release enable; released data line shows the inverse, not the old value
	task automatic close_frame();
		wt(4);
		select_strobe_n = LVL_FULL;
		shift_data_pin = ~shift_data_pin;
	endtask
endmodule // acp_host_model

//--- bench/acp_top_tb.sv
// Self-checking bench for the configuration port top.
// Assumes the host model owns the three serial pins; bench owns the rest.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module acp_top_tb
	import acp_pkg::*;
;
	logic clock; // Core clock
	logic rst_n; // Core reset, active low
	logic reset_pin; // Device reset pin
	logic [1:0] format_select_pin; // Format pin level code
	logic [1:0] ref_mode_pin; // Reference pin level code
	logic [1:0] select_strobe_n; // Enable level, from host model
	logic shift_clock_pin; // Shift clock, from host model
	logic shift_data_pin; // Shift data, from host model
	logic pin_mode; // Observed outputs from here on
	logic low_speed;
	logic standby;
	logic offset_binary;
	logic parallel_iface;
	logic external_ref;
	logic word_commit;
	logic signed [3:0] strobe_rise_shift;
	logic signed [3:0] strobe_fall_shift;
	logic [7:0] number_format_control;
	logic [7:0] output_interface_and_soft_reset;
	logic [7:0] voltage_source_select;
	int fail_count = 0, cmp_count = 0, commits = 0, cycles = 0;
	// Expected strobe shifts by enable level: parallel, then differential rise/fall
	logic signed [3:0] cm[4] = '{SHIFT_P3, SHIFT_P5, SHIFT_M3, SHIFT_NONE};
	logic signed [3:0] lr[4] = '{SHIFT_P7, SHIFT_P7, SHIFT_P3, SHIFT_NONE};
	logic signed [3:0] lf[4] = '{SHIFT_P6, SHIFT_P6, SHIFT_P3, SHIFT_NONE};
	logic ob[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
	logic pa[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
	acp_top dut_u (.clock(clock), .rst_n(rst_n), .reset_pin(reset_pin),
		.select_strobe_n(select_strobe_n), .shift_clock_pin(shift_clock_pin),
		.shift_data_pin(shift_data_pin), .format_select_pin(format_select_pin),
		.ref_mode_pin(ref_mode_pin), .pin_mode(pin_mode), .low_speed(low_speed),
		.standby(standby), .offset_binary(offset_binary), .parallel_iface(parallel_iface),
		.external_ref(external_ref), .strobe_rise_shift(strobe_rise_shift),
		.strobe_fall_shift(strobe_fall_shift), .number_format_control(number_format_control),
		.output_interface_and_soft_reset(output_interface_and_soft_reset),
		.voltage_source_select(voltage_source_select), .word_commit(word_commit));
	acp_host_model host_u (.clock(clock), .select_strobe_n(select_strobe_n),
		.shift_clock_pin(shift_clock_pin), .shift_data_pin(shift_data_pin));
	// Core clock, 100 MHz
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Commit counter and hang guard; falling edge sees settled outputs
	always @(negedge clock) begin
		cycles++;
		if (word_commit === 1'b1) commits++;
		if (cycles == 12000) begin
			fail_count++;
			test_done();
		end
	end
	// Verdict in one place
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// One whole serial word, then time to land
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.open_frame(LVL_GND);
		host_u.put({a, d}, 16);
		host_u.close_frame();
		host_u.wt(10);
	endtask
	task automatic chk_regs(input logic [7:0] f, input logic [7:0] i, input logic [7:0] v);
		`CHK(number_format_control, f)
		`CHK(output_interface_and_soft_reset, i)
		`CHK(voltage_source_select, v)
	endtask
	initial begin
		rst_n = 1'b0;
		reset_pin = 1'b0;
		format_select_pin = LVL_GND;
		ref_mode_pin = LVL_GND;
		host_u.wt(5);
		rst_n = 1'b1;
		host_u.wt(4);
		chk_regs(RST_NUMBER_FORMAT, RST_IFACE_SOFT_RST, RST_VOLTAGE_SRC);
		$display("test reset defaults done");
		// Pin-only mode: every strap level against every format level
		reset_pin = 1'b1;
		for (int f = 0; f < 4; f++) begin
			for (int e = 0; e < 4; e++) begin
				format_select_pin = 2'(f);
				ref_mode_pin = 2'(e);
				host_u.set_static(2'(e), e[0], e[1]);
				host_u.wt(8);
				`CHK(pin_mode, 1'b1)
				`CHK(low_speed, e[0])
				`CHK(standby, e[1])
				`CHK(offset_binary, ob[f])
				`CHK(parallel_iface, pa[f])
				`CHK(external_ref, (e == 1 || e == 2))
				`CHK(strobe_rise_shift, pa[f] ? cm[e] : lr[e])
				`CHK(strobe_fall_shift, pa[f] ? cm[e] : lf[e])
			end
		end
		$display("test pin mode done");
		// Serial mode: straps low, registers reset by pulse first
		host_u.set_static(LVL_FULL, 1'b1, 1'b0);
		format_select_pin = LVL_GND;
		ref_mode_pin = LVL_GND;
		reset_pin = 1'b0;
		host_u.wt(3);
		reset_pin = 1'b1;
		host_u.wt(3);
		reset_pin = 1'b0;
		host_u.wt(6);
		wr(ADDR_NUMBER_FORMAT, 8'h89);
		chk_regs(8'h89, 8'h00, 8'h00);
		`CHK({standby, offset_binary, low_speed, parallel_iface}, 4'hE)
		`CHK({pin_mode, strobe_rise_shift}, 5'h00)
		format_select_pin = LVL_3_8;
		host_u.wt(8);
		`CHK({offset_binary, parallel_iface}, 2'h1)
		format_select_pin = LVL_GND;
		$display("test serial write done");
		// Two words and a short tail in one enable period
		commits = 0;
		host_u.open_frame(LVL_3_8);
		host_u.put({ADDR_VOLTAGE_SRC, 8'h10}, 16);
		host_u.put({ADDR_IFACE_SOFT_RST, 8'h18}, 16);
		host_u.put(16'hFFFF, 7);
		host_u.close_frame();
		host_u.wt(10);
		`CHK(commits, 2)
		chk_regs(8'h89, 8'h18, 8'h10);
		`CHK({external_ref, parallel_iface}, 2'h3)
		ref_mode_pin = LVL_FULL;
		host_u.wt(8);
		`CHK(external_ref, 1'b0)
		ref_mode_pin = LVL_GND;
		$display("test multi word done");
		// Shifting with enable high is ignored; unmapped address changes nothing
		commits = 0;
		host_u.open_frame(LVL_5_8);
		host_u.put({ADDR_NUMBER_FORMAT, 8'h00}, 16);
		host_u.close_frame();
		host_u.wt(10);
		wr(8'h65, 8'hFF);
		`CHK(commits, 1)
		chk_regs(8'h89, 8'h18, 8'h10);
		$display("test refused done");
		// Field value 01 forces differential against a parallel pin
		wr(ADDR_IFACE_SOFT_RST, 8'h08);
		format_select_pin = LVL_3_8;
		host_u.wt(8);
		`CHK(output_interface_and_soft_reset, 8'h08)
		`CHK(parallel_iface, 1'b0)
		format_select_pin = LVL_GND;
		host_u.wt(4);
		$display("test interface override done");
		// Soft reset, then reset pin pulse
		wr(ADDR_IFACE_SOFT_RST, 8'h02);
		chk_regs(8'h00, 8'h00, 8'h00);
		`CHK(external_ref, 1'b0)
		wr(ADDR_NUMBER_FORMAT, 8'h01);
		`CHK(number_format_control, 8'h01)
		reset_pin = 1'b1;
		host_u.wt(3);
		reset_pin = 1'b0;
		host_u.wt(6);
		`CHK(number_format_control, 8'h00)
		$display("test resets done");
		test_done();
	end
endmodule // acp_top_tb

//--- common/acp_pkg.sv
// Constants for the converter configuration port: register map, field
// positions, reset values, pin level codes and timing.
// Assumes a single 100 MHz core clock and pin levels already quantised
// to a two-bit code by the pad ring.
package acp_pkg;
	// Pin level codes as delivered by the level detector
	localparam logic [1:0] LVL_GND = 2'h0; // Ground
	localparam logic [1:0] LVL_3_8 = 2'h1; // Three-eighths supply
	localparam logic [1:0] LVL_5_8 = 2'h2; // Five-eighths supply
	localparam logic [1:0] LVL_FULL = 2'h3; // Full supply
	// Register addresses
	localparam logic [7:0] ADDR_NUMBER_FORMAT = 8'h63; // number_format_control
	localparam logic [7:0] ADDR_IFACE_SOFT_RST = 8'h6C; // output_interface_and_soft_reset
	localparam logic [7:0] ADDR_VOLTAGE_SRC = 8'h6D; // voltage_source_select
	// Field positions
	localparam int STANDBY_BIT = 7; // Global power down in 0x63
	localparam int FORMAT_BIT = 3; // Number format bit in 0x63
	localparam int LOW_SPEED_BIT = 0; // Low speed in 0x63
	localparam int IFACE_LSB = 3; // Output interface field D3-D4 in 0x6C
	localparam int SOFT_RST_BIT = 1; // Self-clearing soft reset in 0x6C
	localparam int REF_BIT = 4; // Reference select in 0x6D
	// Output interface field encodings
	localparam logic [1:0] IFACE_FROM_PIN = 2'h0; // Pin decides
	localparam logic [1:0] IFACE_CMOS = 2'h3; // Parallel single-ended
	// Reset values
	localparam logic [7:0] RST_NUMBER_FORMAT = 8'h00; // After reset
	localparam logic [7:0] RST_IFACE_SOFT_RST = 8'h00; // After reset
	localparam logic [7:0] RST_VOLTAGE_SRC = 8'h00; // After reset
	// Serial word layout
	localparam int WORD_BITS = 16; // Bits per committed word
	localparam int ADDR_BITS = 8; // Address part, sent first
	localparam logic [3:0] LAST_BIT_IDX = 4'hF; // Index of 16th bit
	// Output strobe shifts in 36ths of a sample period
	localparam logic signed [3:0] SHIFT_NONE = 4'sh0; // Default position
	localparam logic signed [3:0] SHIFT_P3 = 4'sh3; // Later by 3/36
	localparam logic signed [3:0] SHIFT_P5 = 4'sh5; // Later by 5/36
	localparam logic signed [3:0] SHIFT_P6 = 4'sh6; // Later by 6/36
	localparam logic signed [3:0] SHIFT_P7 = 4'sh7; // Later by 7/36
	localparam logic signed [3:0] SHIFT_M3 = -4'sh3; // Earlier by 3/36
	// Timing
	localparam int CLK_PERIOD_NS = 10; // Core clock period
	localparam int RST_PULSE_NS = 10; // Least reset pulse width
	localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_STAGES = 2; // Pin synchroniser depth
endpackage

//--- verilog/acp_top.sv
// Configuration front end: strap decoding, write-only three-wire
// serial register port and pin/register priority.
// Assumes pins arrive asynchronously and multi-level pins come in as
// two-bit level codes; the shift clock is sampled, not used as a clock.
`timescale 1ns/1ps

module acp_top
	import acp_pkg::*;
(
	input wire logic clock, // Core clock, 100 MHz
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic reset_pin, // Async reset pin, high active
	input wire logic [1:0] select_strobe_n, // Enable pin level code
	input wire logic shift_clock_pin, // Shift clock pin
	input wire logic shift_data_pin, // Shift data pin, input only
	input wire logic [1:0] format_select_pin, // Format pin level code
	input wire logic [1:0] ref_mode_pin, // Reference pin level code
	output logic pin_mode, // Pin-only configuration active
	output logic low_speed, // Low speed mode
	output logic standby, // Global standby
	output logic offset_binary, // Offset binary, else twos complement
	output logic parallel_iface, // Parallel output, else differential
	output logic external_ref, // External reference selected
	output logic signed [3:0] strobe_rise_shift, // Rise edge shift, 36ths
	output logic signed [3:0] strobe_fall_shift, // Fall edge shift, 36ths
	output logic [7:0] number_format_control, // Number_format_control contents
	output logic [7:0] output_interface_and_soft_reset, // Output_interface_and_soft_reset
	output logic [7:0] voltage_source_select, // Voltage_source_select contents
	output logic word_commit // One-cycle pulse per committed word
);
	localparam int NPIN = 9; // Width of synchronised pin bundle

	// Two-stage synchroniser; stage one is read only by stage two
	logic [NPIN-1:0] pin_meta_reg; // First stage
	logic [NPIN-1:0] pin_sync_reg; // Second stage
	logic sclk_prev_reg; // Previous synchronised shift clock
	logic [WORD_BITS-2:0] shift_reg; // Bits received so far
	logic [3:0] bit_cnt_reg; // Bits received in current word
	logic [7:0] fmt_reg; // number_format_control storage
	logic [7:0] ifc_reg; // output_interface_and_soft_reset storage
	logic [7:0] vsrc_reg; // voltage_source_select storage

	// Named views of the synchronised bundle
	wire rst_pin_s = pin_sync_reg[8]; // Reset pin
	wire [1:0] sen_lvl = pin_sync_reg[7:6]; // Enable pin level
	wire sclk_s = pin_sync_reg[5]; // Shift clock
	wire shift_data_pin_s = pin_sync_reg[4]; // Shift data
	wire [1:0] fmt_lvl = pin_sync_reg[3:2]; // Format pin level
	wire [1:0] ref_lvl = pin_sync_reg[1:0]; // Reference pin level

	// Serial decode
	// Edges come from the sampled clock, so each shift clock phase must
	// last two core cycles or a fall is lost
	wire sen_low = ~sen_lvl[1]; // Enable active when level low
	wire sclk_fall = sclk_prev_reg & ~sclk_s; // Falling edge seen
	wire shift_en = sclk_fall & sen_low & ~rst_pin_s;
	wire word_done = shift_en & (bit_cnt_reg == LAST_BIT_IDX);
	wire [WORD_BITS-1:0] word = {shift_reg, shift_data_pin_s};
	wire [7:0] w_addr = word[WORD_BITS-1 -: ADDR_BITS];
	wire [7:0] w_data = word[7:0]; // Data byte, sent last
	wire wr_fmt = word_done & (w_addr == ADDR_NUMBER_FORMAT); // 0x63 write
	wire wr_ifc = word_done & (w_addr == ADDR_IFACE_SOFT_RST); // 0x6C write
	wire wr_vsrc = word_done & (w_addr == ADDR_VOLTAGE_SRC); // 0x6D write
	wire soft_rst = wr_ifc & w_data[SOFT_RST_BIT];
	wire regs_clear = rst_pin_s | soft_rst;

	// Register next values; soft reset bit is never stored, so it reads 0
	// Clear wins over a write landing in the same cycle
	wire [7:0] fmt_next = regs_clear ? RST_NUMBER_FORMAT : (wr_fmt ? w_data : fmt_reg);
	wire [7:0] ifc_next = regs_clear ? RST_IFACE_SOFT_RST :
		(wr_ifc ? (w_data & ~(8'h01 << SOFT_RST_BIT)) : ifc_reg);
	wire [7:0] vsrc_next = regs_clear ? RST_VOLTAGE_SRC : (wr_vsrc ? w_data : vsrc_reg);

	// Pin decodes
	// Middle levels pick parallel output and external reference
	wire pin_df_ob = (fmt_lvl == LVL_5_8) | (fmt_lvl == LVL_FULL);
	wire pin_par = (fmt_lvl == LVL_3_8) | (fmt_lvl == LVL_5_8);
	wire pin_ext = (ref_lvl == LVL_3_8) | (ref_lvl == LVL_5_8);
	wire [1:0] ifc_field = ifc_reg[IFACE_LSB +: 2]; // Interface field

	// Priority between pins and registers in serial mode
	// Reference and format pins parked off ground outrank their register bits; a nonzero interface field outranks the format pin
	wire ser_ext = (ref_lvl == LVL_GND) ? vsrc_reg[REF_BIT] : pin_ext;
	wire ser_ob = (fmt_lvl == LVL_GND) ? fmt_reg[FORMAT_BIT] : pin_df_ob;
	wire ser_par = (ifc_field == IFACE_FROM_PIN) ? pin_par :
		(ifc_field == IFACE_CMOS);

	wire par_sel = rst_pin_s ? pin_par : ser_par; // Interface in use

	// Strobe shift from enable level; depends on interface in use
	logic signed [3:0] rise_next; // Next rise shift
	logic signed [3:0] fall_next; // Next fall shift

	// Enable level only steers the strobe in pin mode
	always_comb begin
		rise_next = SHIFT_NONE;
		fall_next = SHIFT_NONE;
		if (rst_pin_s && par_sel) begin
			case (sen_lvl)
				LVL_GND: begin
					rise_next = SHIFT_P3;
					fall_next = SHIFT_P3;
				end
				LVL_3_8: begin
					rise_next = SHIFT_P5;
					fall_next = SHIFT_P5;
				end
				LVL_5_8: begin
					rise_next = SHIFT_M3;
					fall_next = SHIFT_M3;
				end
				default: begin
					rise_next = SHIFT_NONE;
					fall_next = SHIFT_NONE;
				end
			endcase
		end else if (rst_pin_s) begin
			case (sen_lvl)
				LVL_GND, LVL_3_8: begin
					rise_next = SHIFT_P7;
					fall_next = SHIFT_P6;
				end
				LVL_5_8: begin
					rise_next = SHIFT_P3;
					fall_next = SHIFT_P3;
				end
				default: begin
					rise_next = SHIFT_NONE;
					fall_next = SHIFT_NONE;
				end
			endcase
		end
	end

	// Synchroniser; pins are asynchronous to the core clock
	// Straps are static, so a torn level code in transit is harmless
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
		end else begin
			pin_meta_reg <= {reset_pin, select_strobe_n, shift_clock_pin,
				shift_data_pin, format_select_pin, ref_mode_pin};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// Shift engine; oversampling lets any rate up to 20 MHz through
	// Count clears whenever enable rises, so a short tail never leaks
	// into the first word of the next frame
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sclk_prev_reg <= 1'b0;
			shift_reg <= '0;
			bit_cnt_reg <= '0;
		end else begin
			sclk_prev_reg <= sclk_s;
			if (!sen_low || rst_pin_s) begin
				bit_cnt_reg <= '0;
			end else if (shift_en) begin
				shift_reg <= word[WORD_BITS-2:0];
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
		end
	end

	// Register file; shift data pin is never driven back
	// Pin mode holds registers at default, so writes made there are lost
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fmt_reg <= RST_NUMBER_FORMAT;
			ifc_reg <= RST_IFACE_SOFT_RST;
			vsrc_reg <= RST_VOLTAGE_SRC;
		end else begin
			fmt_reg <= fmt_next;
			ifc_reg <= ifc_next;
			vsrc_reg <= vsrc_next;
		end
	end

	// Effective configuration, registered onto the outputs
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pin_mode <= 1'b0;
			low_speed <= 1'b0;
			standby <= 1'b0;
			offset_binary <= 1'b0;
			parallel_iface <= 1'b0;
			external_ref <= 1'b0;
			strobe_rise_shift <= SHIFT_NONE;
			strobe_fall_shift <= SHIFT_NONE;
			word_commit <= 1'b0;
		end else begin
			pin_mode <= rst_pin_s;
			low_speed <= rst_pin_s ? sclk_s : fmt_reg[LOW_SPEED_BIT];
			standby <= rst_pin_s ? shift_data_pin_s : fmt_reg[STANDBY_BIT];
			offset_binary <= rst_pin_s ? pin_df_ob : ser_ob;
			parallel_iface <= par_sel;
			external_ref <= rst_pin_s ? pin_ext : ser_ext;
			strobe_rise_shift <= rise_next;
			strobe_fall_shift <= fall_next;
			word_commit <= word_done;
		end
	end

	// Register contents shown as outputs
	assign number_format_control = fmt_reg;
	assign output_interface_and_soft_reset = ifc_reg;
	assign voltage_source_select = vsrc_reg;

	// Pin mode: data pin drives standby
	a_pin_standby: assert property (@(posedge clock) disable iff (!rst_n)
		rst_pin_s |=> standby == $past(shift_data_pin_s))
		else $error("standby does not follow data pin in pin mode");
	// Pin mode: clock pin drives low speed
	a_pin_speed: assert property (@(posedge clock) disable iff (!rst_n)
		rst_pin_s |=> low_speed == $past(sclk_s))
		else $error("low speed does not follow clock pin in pin mode");
	// Reset pin holds registers at default
	a_hw_reset_clear: assert property (@(posedge clock) disable iff (!rst_n)
		rst_pin_s |=> (fmt_reg == RST_NUMBER_FORMAT) && (vsrc_reg == RST_VOLTAGE_SRC))
		else $error("registers not at defaults after reset pin");
	// Soft reset clears the file on the next cycle
	a_soft_reset: assert property (@(posedge clock) disable iff (!rst_n)
		soft_rst |=> (ifc_reg == RST_IFACE_SOFT_RST) && (fmt_reg == RST_NUMBER_FORMAT))
		else $error("soft reset did not clear registers");
	// Soft reset bit is never stored
	a_soft_bit_zero: assert property (@(posedge clock) disable iff (!rst_n)
		!ifc_reg[SOFT_RST_BIT])
		else $error("soft reset bit did not self clear");
	// Commit pulse must trace back to a sixteenth accepted edge
	a_commit_count: assert property (@(posedge clock) disable iff (!rst_n)
		word_commit |-> $past(shift_en) && $past(bit_cnt_reg) == LAST_BIT_IDX
			&& bit_cnt_reg == 4'h0)
		else $error("word commit not on sixteenth edge");
	// Count only moves on an accepted fall
	a_shift_hold: assert property (@(posedge clock) disable iff (!rst_n)
		(!shift_en && sen_low && !rst_pin_s) |=> $stable(bit_cnt_reg))
		else $error("bit count moved without falling clock edge");
	// Reference pin off ground outranks the register bit
	a_ref_priority: assert property (@(posedge clock) disable iff (!rst_n)
		(!rst_pin_s && ref_lvl != LVL_GND) |=> external_ref == $past(pin_ext))
		else $error("reference register overrode a high pin");
	// Format bit rules while the format pin is grounded
	a_fmt_priority: assert property (@(posedge clock) disable iff (!rst_n)
		(!rst_pin_s && fmt_lvl == LVL_GND) |=> offset_binary == $past(fmt_reg[FORMAT_BIT]))
		else $error("format bit ignored while pin low");
	// Nonzero interface field outranks the format pin
	a_iface_override: assert property (@(posedge clock) disable iff (!rst_n)
		(!rst_pin_s && ifc_field != IFACE_FROM_PIN) |=> parallel_iface == $past(ifc_field == IFACE_CMOS))
		else $error("interface field failed to override pin");

	// Further checks on pin mode, strobe, shifting and storage
	// Pin mode: flag follows the reset pin one cycle later
	a_pin_mode_flag: assert property (@(posedge clock) disable iff (!rst_n)
		rst_pin_s |=> pin_mode)
		else $error("pin mode flag not set while reset pin high");
	// Pin mode: serial shifter stays idle
	a_pin_no_shift: assert property (@(posedge clock) disable iff (!rst_n)
		rst_pin_s |=> bit_cnt_reg == 4'h0)
		else $error("shifter counted while in pin mode");
	// Pin mode: format pin alone sets format and interface
	a_pin_format: assert property (@(posedge clock) disable iff (!rst_n)
		rst_pin_s |=> offset_binary == $past(pin_df_ob) && parallel_iface == $past(pin_par))
		else $error("format pin decode not applied in pin mode");
	// Serial mode: strobe stays at its default position
	a_strobe_serial: assert property (@(posedge clock) disable iff (!rst_n)
		!rst_pin_s |=> strobe_rise_shift == SHIFT_NONE && strobe_fall_shift == SHIFT_NONE)
		else $error("strobe shifted outside pin mode");
	// Enable high drops any partial word
	a_enable_drop: assert property (@(posedge clock) disable iff (!rst_n)
		!sen_low |=> bit_cnt_reg == 4'h0)
		else $error("partial word kept across enable high");
	// Newest bit enters at the bottom, older bits move up
	a_shift_order: assert property (@(posedge clock) disable iff (!rst_n)
		shift_en |=> shift_reg[0] == $past(shift_data_pin_s) && shift_reg[1] == $past(shift_reg[0]))
		else $error("shift register order broken");
	// Data byte of a committed word lands unchanged
	a_data_byte: assert property (@(posedge clock) disable iff (!rst_n)
		wr_vsrc |=> vsrc_reg == $past(w_data))
		else $error("data byte not stored as sent");
endmodule // acp_top
